// ---- dam_pkg.sv ----
package dam_pkg;

   // configuration space offsets
   localparam logic [7:0] ACT_EVT_OFFSET = 8'h58;
   localparam logic [7:0] RES_DEC_OFFSET = 8'h5C;

   localparam logic [31:0] ACT_EVT_RESET = 32'h0000_0000;
   localparam logic [31:0] RES_DEC_RESET = 32'h0000_0000;
   localparam logic [31:0] ACT_EVT_WMASK = 32'h03FF_FF77;

   // activity register fields
   localparam int CMD_SMI_BIT   = 25;
   localparam int VIDEO_EN_BIT  = 24;
   localparam int PCT_HI        = 23;
   localparam int PCT_LO        = 16;
   localparam int PHASE_HI      = 15;
   localparam int PHASE_LO      = 8;
   localparam int IRQ_GRLD_BIT  = 6;
   localparam int RTC_CEV_BIT   = 5;
   localparam int WAKE_CEV_BIT  = 4;
   localparam int KBM_GRLD_BIT  = 2;
   localparam int IRQ_CEV_BIT   = 1;
   localparam int TMR_CEV_BIT   = 0;

   // resource register fields
   localparam int LPT_FWD_BIT   = 31;
   localparam int GENB_FWD_BIT  = 30;
   localparam int GENA_FWD_BIT  = 29;
   localparam int KBD_DEC_BIT   = 28;
   localparam int SEG_DEC_BIT   = 27;
   localparam int GIO_DEC_BIT   = 26;
   localparam int SND_FWD_BIT   = 25;
   localparam int FW_DEC_BIT    = 24;
   localparam int FW_MASK_HI    = 23;
   localparam int FW_MASK_LO    = 22;
   localparam int FW_BASE_HI    = 21;
   localparam int FW_BASE_LO    = 10;

   // irq lines
   localparam int IRQ_TIMER     = 0;
   localparam int IRQ_KBD       = 1;
   localparam int IRQ_RTC       = 8;
   localparam int IRQ_MOUSE     = 12;
   localparam logic [15:0] IRQ_GENERAL = 16'hFEFA;

   // address ranges
   localparam logic [15:0] KBD_DATA_PORT = 16'h0060;
   localparam logic [15:0] KBD_CMD_PORT  = 16'h0064;
   localparam logic [15:0] GIO_LO        = 16'h03B0;
   localparam logic [15:0] GIO_HI        = 16'h03DF;
   localparam logic [31:0] SEG_LO        = 32'h000A_0000;
   localparam logic [31:0] SEG_HI        = 32'h000B_FFFF;

   // slice timing: 256 clocks per slice, 256 slices per window
   localparam int SLICE_CLOCKS = 256;
   localparam int WINDOW_SLICES = 256;
   localparam logic [7:0] SLICE_LAST  = 8'(SLICE_CLOCKS - 1);
   localparam logic [7:0] WINDOW_LAST = 8'(WINDOW_SLICES - 1);

   typedef struct packed {
      logic        valid;
      logic        is_io;
      logic [31:0] addr;
   } dam_pci_access_s;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [7:0]  offset;
      logic [31:0] wdata;
   } dam_cfg_req_s;

   typedef struct packed {
      logic lpt_range;
      logic genb_mem;
      logic genb_io;
      logic gena_mem;
      logic gena_io;
      logic snd_range;
   } dam_ext_match_s;

endpackage : dam_pkg

// ---- dam_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module dam_monitor (
   // clock and reset
   input  wire logic                     clock_i,
   input  wire logic                     srst_i,
   // configuration access
   input  wire dam_pkg::dam_cfg_req_s    cfg_req_i,
   input  wire logic                     cmd_port_read_i,
   input  wire logic                     smi_gen_enable_i,
   output logic      [31:0]              cfg_rdata_o,
   // event sources
   input  wire logic [15:0]              irq_i,
   input  wire logic [15:0]              irq_mask_i,
   input  wire logic                     nmi_i,
   input  wire logic                     init_i,
   input  wire logic                     smi_active_i,
   input  wire logic                     general_input_one_n_i,
   input  wire logic                     power_button_input_n_i,
   input  wire logic                     cover_switch_input_i,
   input  wire logic                     data_phase_i,
   // pci access decode
   input  wire dam_pkg::dam_pci_access_s pci_access_i,
   input  wire dam_pkg::dam_ext_match_s  ext_match_i,
   input  wire logic                     parallel_port_monitor_enable_i,
   input  wire logic                     generic_b_memory_enable_i,
   input  wire logic                     generic_b_io_enable_i,
   input  wire logic                     generic_a_memory_enable_i,
   input  wire logic                     generic_a_io_enable_i,
   input  wire logic                     sound_card_decode_enable_i,
   // events out
   output logic                          smi_n_o,
   output logic                          standby_reload_o,
   output logic                          clock_event_o,
   output logic                          fast_burst_event_o,
   output logic                          dev11_reload_o,
   output logic                          extended_io_claim_o,
   output logic                          kbd_hit_o,
   output logic                          segment_hit_o,
   output logic                          graphics_io_hit_o,
   output logic                          frame_window_hit_o
);

   logic [31:0] act_q;
   logic [31:0] res_q;
   logic [15:0] irq_s1_q;
   logic [15:0] irq_s2_q;
   logic [15:0] irq_prev_q;
   logic [5:0]  misc_s1_q;
   logic [5:0]  misc_s2_q;
   logic [5:0]  misc_prev_q;
   logic        phase_s1_q;
   logic        phase_s2_q;
   logic [7:0]  clk_cnt_q;
   logic [8:0]  phase_cnt_q;
   logic [7:0]  slice_idx_q;
   logic [8:0]  marked_cnt_q;
   logic [15:0] irq_rise;
   logic [5:0]  misc_rise;
   logic        general_rise;
   logic        slice_end;
   logic        slice_counted;
   logic        window_end;
   logic [8:0]  marked_total;

   function automatic logic in_range16(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
      in_range16 = (a >= lo) && (a <= hi);
   endfunction : in_range16

   function automatic logic window_match(input logic [31:0] a, input logic [31:0] res);
      logic [1:0] keep;
      keep = ~res[dam_pkg::FW_MASK_HI:dam_pkg::FW_MASK_LO];
      window_match = (a[31:22] == res[dam_pkg::FW_BASE_HI:dam_pkg::FW_BASE_LO + 2]) &&
                     (((a[21:20] ^ res[dam_pkg::FW_BASE_LO + 1:dam_pkg::FW_BASE_LO]) & keep) == 2'h0);
   endfunction : window_match

   // configuration registers
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         act_q <= dam_pkg::ACT_EVT_RESET;
         res_q <= dam_pkg::RES_DEC_RESET;
      end else if (cfg_req_i.valid && cfg_req_i.write) begin
         if (cfg_req_i.offset == dam_pkg::ACT_EVT_OFFSET) begin
            act_q <= cfg_req_i.wdata & dam_pkg::ACT_EVT_WMASK;
         end else if (cfg_req_i.offset == dam_pkg::RES_DEC_OFFSET) begin
            res_q <= cfg_req_i.wdata;
         end
      end
   end

   // read data
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         cfg_rdata_o <= 32'h0000_0000;
      end else if (cfg_req_i.valid && !cfg_req_i.write) begin
         if (cfg_req_i.offset == dam_pkg::ACT_EVT_OFFSET) begin
            cfg_rdata_o <= act_q;
         end else if (cfg_req_i.offset == dam_pkg::RES_DEC_OFFSET) begin
            cfg_rdata_o <= res_q;
         end else begin
            cfg_rdata_o <= 32'h0000_0000;
         end
      end
   end

   // pin synchronisers
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         irq_s1_q    <= 16'h0000;
         irq_s2_q    <= 16'h0000;
         irq_prev_q  <= 16'h0000;
         misc_s1_q   <= 6'h00;
         misc_s2_q   <= 6'h00;
         misc_prev_q <= 6'h00;
         phase_s1_q  <= 1'b0;
         phase_s2_q  <= 1'b0;
      end else begin
         irq_s1_q    <= irq_i & ~irq_mask_i;
         irq_s2_q    <= irq_s1_q;
         irq_prev_q  <= irq_s2_q;
         misc_s1_q   <= {nmi_i, init_i, smi_active_i, ~general_input_one_n_i,
                         ~power_button_input_n_i, cover_switch_input_i};
         misc_s2_q   <= misc_s1_q;
         misc_prev_q <= misc_s2_q;
         phase_s1_q  <= data_phase_i;
         phase_s2_q  <= phase_s1_q;
      end
   end

   assign irq_rise     = irq_s2_q & ~irq_prev_q;
   assign misc_rise    = misc_s2_q & ~misc_prev_q;
   assign general_rise = (|(irq_rise & dam_pkg::IRQ_GENERAL)) || misc_rise[5] || misc_rise[4];

   // activity events
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         standby_reload_o   <= 1'b0;
         clock_event_o      <= 1'b0;
         fast_burst_event_o <= 1'b0;
      end else begin
         standby_reload_o <= (act_q[dam_pkg::IRQ_GRLD_BIT] && general_rise) ||
                             (act_q[dam_pkg::KBM_GRLD_BIT] &&
                              (irq_rise[dam_pkg::IRQ_KBD] || irq_rise[dam_pkg::IRQ_MOUSE]));
         fast_burst_event_o <= (act_q[dam_pkg::RTC_CEV_BIT] && irq_rise[dam_pkg::IRQ_RTC]) ||
                               (act_q[dam_pkg::WAKE_CEV_BIT] && (|misc_rise[3:0]));
         clock_event_o <= (act_q[dam_pkg::IRQ_CEV_BIT] && general_rise) ||
                          (act_q[dam_pkg::TMR_CEV_BIT] && irq_rise[dam_pkg::IRQ_TIMER]) ||
                          (act_q[dam_pkg::RTC_CEV_BIT] && irq_rise[dam_pkg::IRQ_RTC]) ||
                          (act_q[dam_pkg::WAKE_CEV_BIT] && (|misc_rise[3:0]));
      end
   end

   // command port smi
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         smi_n_o <= 1'b1;
      end else begin
         smi_n_o <= ~(cmd_port_read_i && smi_gen_enable_i && act_q[dam_pkg::CMD_SMI_BIT]);
      end
   end

   // slice timing
   assign slice_end     = (clk_cnt_q == dam_pkg::SLICE_LAST);
   assign slice_counted = (phase_cnt_q > {1'b0, act_q[dam_pkg::PHASE_HI:dam_pkg::PHASE_LO]});
   assign window_end    = slice_end && (slice_idx_q == dam_pkg::WINDOW_LAST);
   assign marked_total  = marked_cnt_q + {8'h00, slice_end && slice_counted};

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         clk_cnt_q   <= 8'h00;
         phase_cnt_q <= 9'h000;
      end else begin
         clk_cnt_q <= clk_cnt_q + 8'h01;
         if (slice_end) begin
            phase_cnt_q <= {8'h00, phase_s2_q};
         end else if (phase_s2_q && phase_cnt_q != 9'h1FF) begin
            phase_cnt_q <= phase_cnt_q + 9'h001;
         end
      end
   end

   // window accumulation
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         slice_idx_q    <= 8'h00;
         marked_cnt_q   <= 9'h000;
         dev11_reload_o <= 1'b0;
      end else begin
         dev11_reload_o <= 1'b0;
         if (slice_end) begin
            slice_idx_q  <= slice_idx_q + 8'h01;
            if (window_end) begin
               marked_cnt_q   <= 9'h000;
               dev11_reload_o <= act_q[dam_pkg::VIDEO_EN_BIT] &&
                                 (marked_total >= {1'b0, act_q[dam_pkg::PCT_HI:dam_pkg::PCT_LO]});
            end else begin
               marked_cnt_q <= marked_total;
            end
         end
      end
   end

   // address decode
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         extended_io_claim_o <= 1'b0;
         kbd_hit_o          <= 1'b0;
         segment_hit_o      <= 1'b0;
         graphics_io_hit_o  <= 1'b0;
         frame_window_hit_o <= 1'b0;
      end else begin
         extended_io_claim_o <= pci_access_i.valid && (
            (res_q[dam_pkg::LPT_FWD_BIT] && parallel_port_monitor_enable_i && ext_match_i.lpt_range) ||
            (res_q[dam_pkg::GENB_FWD_BIT] &&
             ((generic_b_memory_enable_i && ext_match_i.genb_mem) ||
              (generic_b_io_enable_i && ext_match_i.genb_io))) ||
            (res_q[dam_pkg::GENA_FWD_BIT] &&
             ((generic_a_memory_enable_i && ext_match_i.gena_mem) ||
              (generic_a_io_enable_i && ext_match_i.gena_io))) ||
            (res_q[dam_pkg::SND_FWD_BIT] && sound_card_decode_enable_i && ext_match_i.snd_range));
         kbd_hit_o <= pci_access_i.valid && pci_access_i.is_io && res_q[dam_pkg::KBD_DEC_BIT] &&
                      ((pci_access_i.addr[15:0] == dam_pkg::KBD_DATA_PORT) ||
                       (pci_access_i.addr[15:0] == dam_pkg::KBD_CMD_PORT));
         segment_hit_o <= pci_access_i.valid && !pci_access_i.is_io && res_q[dam_pkg::SEG_DEC_BIT] &&
                          (pci_access_i.addr >= dam_pkg::SEG_LO) &&
                          (pci_access_i.addr <= dam_pkg::SEG_HI);
         graphics_io_hit_o <= pci_access_i.valid && pci_access_i.is_io && res_q[dam_pkg::GIO_DEC_BIT] &&
                              in_range16(pci_access_i.addr[15:0], dam_pkg::GIO_LO, dam_pkg::GIO_HI);
         frame_window_hit_o <= pci_access_i.valid && !pci_access_i.is_io && res_q[dam_pkg::FW_DEC_BIT] &&
                               window_match(pci_access_i.addr, res_q);
      end
   end

endmodule : dam_monitor
`default_nettype wire

// ---- dam_pci_master_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module dam_pci_master_model (
   // clock and reset
   input  wire logic clock_i,
   input  wire logic srst_i,
   // traffic control
   input  wire logic active_i,
   output logic      data_phase_o
);
   logic [1:0] beat_q;
   // three data phases, then one turnaround
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         beat_q <= 2'h0;
      end else begin
         beat_q <= beat_q + 2'h1;
      end
   end
   assign data_phase_o = active_i && (beat_q != 2'h3);
endmodule : dam_pci_master_model
`default_nettype wire

// ---- dam_monitor_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module dam_monitor_chk (
   // clock and reset
   input wire logic                     clock_i,
   input wire logic                     srst_i,
   // watched ports
   input wire dam_pkg::dam_cfg_req_s    cfg_req_i,
   input wire logic                     cmd_port_read_i,
   input wire logic                     smi_gen_enable_i,
   input wire logic [31:0]              cfg_rdata_o,
   input wire logic [15:0]              irq_i,
   input wire logic [15:0]              irq_mask_i,
   input wire dam_pkg::dam_pci_access_s pci_access_i,
   input wire logic                     smi_n_o,
   input wire logic                     standby_reload_o,
   input wire logic                     clock_event_o,
   input wire logic                     fast_burst_event_o,
   input wire logic                     dev11_reload_o,
   input wire logic                     kbd_hit_o,
   input wire logic                     segment_hit_o,
   input wire logic                     graphics_io_hit_o,
   input wire logic                     frame_window_hit_o
);
   logic [31:0] act_q;
   logic [31:0] res_q;
   logic [31:0] rd_exp;
   logic [31:0] pa;
   logic        pv;
   logic        io;
   // shadow copies of both registers
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         act_q <= 32'h0000_0000;
      end else if (cfg_req_i.valid && cfg_req_i.write && cfg_req_i.offset == dam_pkg::ACT_EVT_OFFSET) begin
         act_q <= cfg_req_i.wdata & dam_pkg::ACT_EVT_WMASK;
      end
   end
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         res_q <= 32'h0000_0000;
      end else if (cfg_req_i.valid && cfg_req_i.write && cfg_req_i.offset == dam_pkg::RES_DEC_OFFSET) begin
         res_q <= cfg_req_i.wdata;
      end
   end
   always_comb begin
      pa = pci_access_i.addr;
      pv = pci_access_i.valid;
      io = pci_access_i.is_io;
      rd_exp = (cfg_req_i.offset == dam_pkg::ACT_EVT_OFFSET) ? act_q :
               (cfg_req_i.offset == dam_pkg::RES_DEC_OFFSET) ? res_q : 32'h0000_0000;
   end
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (srst_i);
   sequence s_irq_up(n);
      $rose(irq_i[n]) && !irq_mask_i[n];
   endsequence
   AST_SMI: assert property (1 |=> smi_n_o == !$past(cmd_port_read_i && act_q[25] && smi_gen_enable_i))
      else $error("smi output wrong");
   AST_RDATA: assert property (cfg_req_i.valid && !cfg_req_i.write |=> cfg_rdata_o == $past(rd_exp))
      else $error("read data wrong");
   AST_KBD: assert property (1 |=> kbd_hit_o == $past(pv && io && res_q[28] && (pa[15:0] == 16'h0060 || pa[15:0] == 16'h0064)))
      else $error("keyboard decode wrong");
   AST_SEG: assert property (1 |=> segment_hit_o == $past(pv && !io && res_q[27] && pa >= 32'h000A_0000 && pa <= 32'h000B_FFFF))
      else $error("segment decode wrong");
   AST_GIO: assert property (1 |=> graphics_io_hit_o == $past(pv && io && res_q[26] && pa[15:0] >= 16'h03B0 && pa[15:0] <= 16'h03DF))
      else $error("graphics io decode wrong");
   AST_FW: assert property (1 |=> frame_window_hit_o == $past(pv && !io && res_q[24] && ((pa[31:20] ^ res_q[21:10]) & ~{10'h000, res_q[23:22]}) == 12'h000))
      else $error("frame window decode wrong");
   AST_TMR: assert property (s_irq_up(0) ##0 act_q[0] |-> ##[2:4] clock_event_o)
      else $error("timer irq event missing");
   AST_STBY: assert property (s_irq_up(1) ##0 act_q[2] |-> ##[2:4] standby_reload_o)
      else $error("keyboard reload missing");
   AST_FAST: assert property (s_irq_up(8) ##0 act_q[5] |-> ##[2:4] fast_burst_event_o)
      else $error("rtc fast event missing");
   AST_DEV11: assert property (dev11_reload_o |-> $past(act_q[24]))
      else $error("video reload while disabled");
endmodule : dam_monitor_chk
bind dam_monitor dam_monitor_chk u_dam_monitor_chk (.clock_i, .srst_i, .cfg_req_i, .cmd_port_read_i, .smi_gen_enable_i,
   .cfg_rdata_o, .irq_i, .irq_mask_i, .pci_access_i, .smi_n_o, .standby_reload_o, .clock_event_o, .fast_burst_event_o,
   .dev11_reload_o, .kbd_hit_o, .segment_hit_o, .graphics_io_hit_o, .frame_window_hit_o);
`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic                     clock_i = 1'b0;
   logic                     srst_i = 1'b1;
   dam_pkg::dam_cfg_req_s    cfg_req = '0;
   dam_pkg::dam_pci_access_s pci = '0;
   dam_pkg::dam_ext_match_s  ext = '0;
   logic                     cmd_rd = 1'b0;
   logic                     smi_en = 1'b0;
   logic [21:0]              ev = '0;
   logic [15:0]              mask = '0;
   logic [5:0]               en = '0;
   logic                     busy = 1'b0;
   logic                     dphase;
   logic [31:0]              rdata;
   logic                     smi_n, stby, cev, fast, dev11, claim, kbd, seg, gio, fw;
   int                       bad_count = 0;
   int                       n_checks = 0;
   int                       cyc = 0;
   always #5 clock_i = ~clock_i;
   dam_pci_master_model u_dam_pci_master_model (.clock_i(clock_i), .srst_i(srst_i), .active_i(busy),
      .data_phase_o(dphase));
   dam_monitor u_dam_monitor (.clock_i(clock_i), .srst_i(srst_i), .cfg_req_i(cfg_req), .cmd_port_read_i(cmd_rd),
      .smi_gen_enable_i(smi_en), .cfg_rdata_o(rdata), .irq_i(ev[15:0]), .irq_mask_i(mask), .nmi_i(ev[16]),
      .init_i(ev[17]), .smi_active_i(ev[18]), .cover_switch_input_i(ev[19]), .general_input_one_n_i(~ev[20]),
      .power_button_input_n_i(~ev[21]), .data_phase_i(dphase), .pci_access_i(pci), .ext_match_i(ext),
      .parallel_port_monitor_enable_i(en[5]), .generic_b_memory_enable_i(en[4]), .generic_b_io_enable_i(en[3]),
      .generic_a_memory_enable_i(en[2]), .generic_a_io_enable_i(en[1]), .sound_card_decode_enable_i(en[0]),
      .smi_n_o(smi_n), .standby_reload_o(stby), .clock_event_o(cev), .fast_burst_event_o(fast),
      .dev11_reload_o(dev11), .extended_io_claim_o(claim), .kbd_hit_o(kbd), .segment_hit_o(seg),
      .graphics_io_hit_o(gio), .frame_window_hit_o(fw));
   task automatic summarize();
      $display("checks=%0d mismatches=%0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : summarize
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic cfg(input logic wr, input logic [7:0] off, input logic [31:0] d);
      @(posedge clock_i);
      cfg_req <= '{1'b1, wr, off, d};
      @(posedge clock_i);
      cfg_req <= '0;
      #1;
   endtask : cfg
   task automatic rd(input logic [7:0] off, input logic [31:0] exp);
      cfg(1'b0, off, 32'h0000_0000);
      chk(rdata, exp);
   endtask : rd
   task automatic smi(input logic e, input logic exp);
      @(posedge clock_i);
      smi_en <= e;
      cmd_rd <= 1'b1;
      @(posedge clock_i);
      cmd_rd <= 1'b0;
      #1;
      chk({31'h0, smi_n}, {31'h0, exp});
   endtask : smi
   task automatic evt(input int src, input int abit, input int sel, input logic [31:0] n);
      logic [31:0] cnt;
      logic [2:0]  o;
      cnt = 32'h0;
      cfg(1'b1, 8'h58, 32'h1 << abit);
      @(posedge clock_i);
      ev[src] <= 1'b1;
      repeat (10) begin
         @(posedge clock_i);
         #1;
         o = {fast, cev, stby};
         cnt = cnt + {31'h0, o[sel]};
      end
      @(posedge clock_i);
      ev[src] <= 1'b0;
      repeat (8) @(posedge clock_i);
      chk(cnt, n);
   endtask : evt
   task automatic acc(input logic io, input logic [31:0] a, input logic [4:0] exp);
      @(posedge clock_i);
      pci <= '{1'b1, io, a};
      @(posedge clock_i);
      pci <= '0;
      #1;
      chk({27'h0, claim, kbd, seg, gio, fw}, {27'h0, exp});
   endtask : acc
   task automatic clm(input logic [5:0] m, input logic [5:0] e, input logic io, input logic x);
      @(posedge clock_i);
      ext <= m;
      en <= e;
      acc(io, 32'h0000_0300, {x, 4'h0});
   endtask : clm
   always @(posedge clock_i) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         bad_count++;
         summarize();
      end
   end
   initial begin
      repeat (4) @(posedge clock_i);
      srst_i <= 1'b0;
      rd(8'h58, 32'h0000_0000);
      rd(8'h5C, 32'h0000_0000);
      cfg(1'b1, 8'h58, 32'hFFFF_FFF7);
      rd(8'h58, 32'h03FF_FF77);
      cfg(1'b1, 8'h5C, 32'hFFFF_FFFF);
      rd(8'h5C, 32'hFFFF_FFFF);
      rd(8'h60, 32'h0000_0000);
      $display("test registers done");
      @(posedge clock_i);
      srst_i <= 1'b1;
      repeat (2) @(posedge clock_i);
      srst_i <= 1'b0;
      rd(8'h58, 32'h0000_0000);
      rd(8'h5C, 32'h0000_0000);
      chk({31'h0, smi_n}, 32'h0000_0001);
      $display("test reset done");
      cfg(1'b1, 8'h58, 32'h0200_0000);
      smi(1'b1, 1'b0);
      smi(1'b0, 1'b1);
      cfg(1'b1, 8'h58, 32'h0000_0000);
      smi(1'b1, 1'b1);
      $display("test smi done");
      evt(0, 0, 1, 1);
      evt(3, 1, 1, 1);
      evt(16, 1, 1, 1);
      evt(0, 1, 1, 0);
      evt(17, 6, 0, 1);
      evt(3, 6, 0, 1);
      evt(8, 6, 0, 0);
      evt(1, 2, 0, 1);
      evt(12, 2, 0, 1);
      evt(8, 5, 2, 1);
      for (int i = 18; i < 22; i++) evt(i, 4, 2, 1);
      @(posedge clock_i);
      mask <= 16'h0008;
      evt(3, 1, 1, 0);
      @(posedge clock_i);
      mask <= 16'h0000;
      $display("test events done");
      cfg(1'b1, 8'h5C, 32'hFF84_8C00);
      acc(1'b1, 32'h0000_0060, 5'h08);
      acc(1'b1, 32'h0000_0064, 5'h08);
      acc(1'b1, 32'h0000_0061, 5'h00);
      acc(1'b0, 32'h000A_0000, 5'h04);
      acc(1'b0, 32'h000B_FFFF, 5'h04);
      acc(1'b0, 32'h000C_0000, 5'h00);
      acc(1'b1, 32'h0000_03B0, 5'h02);
      acc(1'b1, 32'h0000_03DF, 5'h02);
      acc(1'b1, 32'h0000_03E0, 5'h00);
      acc(1'b0, 32'h1230_0000, 5'h01);
      acc(1'b0, 32'h1330_0000, 5'h00);
      acc(1'b0, 32'h1210_0000, 5'h01);
      acc(1'b0, 32'h1220_0000, 5'h00);
      clm(6'h20, 6'h3F, 1'b1, 1'b1);
      clm(6'h20, 6'h1F, 1'b1, 1'b0);
      clm(6'h01, 6'h3F, 1'b1, 1'b1);
      clm(6'h01, 6'h3E, 1'b1, 1'b0);
      clm(6'h10, 6'h3F, 1'b0, 1'b1);
      clm(6'h10, 6'h2F, 1'b0, 1'b0);
      clm(6'h02, 6'h3F, 1'b1, 1'b1);
      cfg(1'b1, 8'h5C, 32'h0000_0000);
      clm(6'h3F, 6'h3F, 1'b1, 1'b0);
      $display("test decode done");
      cfg(1'b1, 8'h58, 32'h0101_8000);
      @(posedge clock_i);
      busy <= 1'b1;
      for (int k = 0; k < 70000 && dev11 !== 1'b1; k++) begin
         @(posedge clock_i);
         #1;
      end
      chk({31'h0, dev11}, 32'h0000_0001);
      $display("test video done");
      summarize();
   end
endmodule : tb
`default_nettype wire
